// File: logic/autobaud_wake.sv
// Auto-rate calibration, wake-on-break and receiver core with APB registers
//
// Functional notes
// RL1: Calibration enable starts auto-rate sequence
// RL2: Receiver held idle during calibration
// RL3: Count starts at first rise after start
// RL4: Remote sends sync character 55h
// RL5: Stop at fifth rise, keep count
// RL6: Completion clears enable, sets receive flag
// RL7: Software reads data to clear flag
// RL8: Divisor pair forms one 16-bit counter
// RL9: Counter clocked at base rate over eight
// RL10: Divide ratios from width and speed bits
// RL11: Software checks high byte for overflow
// RL12: With wake, calibrate the following character
// RL13: Result exceeds ideal divisor by one
// RL14: Software keeps rate within measurable range
// RL15: Sleep stops rate generator and reception
// RL16: Wake works only in asynchronous mode
// RL17: Wake enable disables reception, watches line
// RL18: Falling edge on line is wake event
// RL19: Wake event sets receive flag
// RL20: Reading receive data clears flag
// RL21: Rising edge ends break, clears wake
// RL22: Software loads 520 for 9600 baud
// RL23: Remote sends all-zero wake character
// RL24: Counter cleared when calibration starts
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module autobaud_wake
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line and power state
  input  wire logic        rx_line,
  input  wire logic        sleep_mode,
  // Status outputs
  output logic             rx_int_flag,
  output logic             wake_enable_out
);

  typedef enum logic [2:0] {CAL_OFF, CAL_HOLD, CAL_START, CAL_FIRST, CAL_COUNT} cal_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

  rate_tick_if tk ();

  rate_prescaler u_prescaler
  (
    .clk (clk),
    .rst (rst),
    .tk  (tk)
  );

  // Control bits
  logic        calib_enable;
  logic        wake_enable;
  logic        wide_divisor_sel;
  logic        high_speed_sel;
  logic        sync_mode;
  logic        rx_enable;
  logic [15:0] divisor;
  logic [7:0]  rx_data_reg;
  logic        wake_seen;
  logic        rx_prev;
  cal_state_e  cal_state;
  cal_state_e  next_cal_state;
  rx_state_e   rx_state;
  logic [2:0]  rise_cnt;
  logic [15:0] bit_cnt;
  logic [3:0]  bit_idx;
  logic [7:0]  shift;

  // Bus decode
  // Registered pready masks the second access cycle
  wire logic access = psel && penable && !pready;
  wire logic wr     = access && pwrite;
  wire logic rd     = access && !pwrite;
  wire logic hit_ctl  = (paddr == autobaud_pkg::OFF_RATE_CONTROL);
  wire logic hit_low  = (paddr == autobaud_pkg::OFF_DIVISOR_LOW);
  wire logic hit_high = (paddr == autobaud_pkg::OFF_DIVISOR_HIGH);
  wire logic hit_data = (paddr == autobaud_pkg::OFF_RX_DATA);
  wire logic hit_stat = (paddr == autobaud_pkg::OFF_STATUS);
  wire logic mapped   = hit_ctl || hit_low || hit_high || hit_data || hit_stat;

  // Line edges
  wire logic rise = rx_line && !rx_prev;
  wire logic fall = !rx_line && rx_prev;

  // RL16 wake needs asynchronous mode
  wire logic wake_active = wake_enable && !sync_mode;
  wire logic calibrating = (cal_state != CAL_OFF);

  // RL18 falling edge while watching
  wire logic wake_event = wake_active && !wake_seen && fall;
  // RL21 break ends on rising edge
  wire logic wake_done  = wake_active && wake_seen && rise;

  // RL5 fifth rise closes the measurement
  wire logic cal_last   = (cal_state == CAL_COUNT) && rise &&
                          (rise_cnt == autobaud_pkg::SYNC_RISE_EDGES - 3'h1);
  wire logic rx_done    = (rx_state == RX_STOP) && tk.base_tick && (bit_cnt == divisor);

  // RL15 no ticks in sleep
  assign tk.run      = !sleep_mode;
  assign tk.wide_sel = wide_divisor_sel;
  assign tk.high_sel = high_speed_sel;

  // Calibration sequencing
  always_comb
  begin
    next_cal_state = cal_state;
    case (cal_state)
      CAL_OFF:
        if (wr && hit_ctl && pwdata[autobaud_pkg::BIT_CALIB_ENABLE])
          // RL1 enable starts sequence
          next_cal_state = CAL_HOLD;
      CAL_HOLD:
        // RL12 wait out the break
        if (!wake_active)
          next_cal_state = CAL_START;
      CAL_START:
        // Start bit of the sync character
        if (fall)
          next_cal_state = CAL_FIRST;
      CAL_FIRST:
        // RL3 first rise after start bit
        if (rise)
          next_cal_state = CAL_COUNT;
      CAL_COUNT:
        // RL5 fifth rise ends the count
        if (cal_last)
          next_cal_state = CAL_OFF;
      default:
        next_cal_state = CAL_OFF;
    endcase
    // Clearing the enable bit aborts calibration
    if (wr && hit_ctl && !pwdata[autobaud_pkg::BIT_CALIB_ENABLE])
      next_cal_state = CAL_OFF;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cal_state <= CAL_OFF;
      rise_cnt  <= 3'h0;
      // Idle level, so no false rise after reset
      rx_prev   <= 1'b1;
    end
    else
    begin
      cal_state <= next_cal_state;
      rx_prev   <= rx_line;
      // Rise that opens the count is number one
      if (cal_state == CAL_FIRST)
        rise_cnt <= 3'h1;
      else if (cal_state == CAL_COUNT && rise)
        rise_cnt <= rise_cnt + 3'h1;
    end
  end

  // Control register and hardware clears
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {rx_enable, sync_mode, high_speed_sel, wide_divisor_sel, wake_enable, calib_enable}
        <= autobaud_pkg::RATE_CONTROL_RESET;
    end
    // Software write wins over the hardware clears
    else if (wr && hit_ctl)
    begin
      calib_enable     <= pwdata[autobaud_pkg::BIT_CALIB_ENABLE];
      wake_enable      <= pwdata[autobaud_pkg::BIT_WAKE_ENABLE];
      wide_divisor_sel <= pwdata[autobaud_pkg::BIT_WIDE_DIV_SEL];
      high_speed_sel   <= pwdata[autobaud_pkg::BIT_HIGH_SPD_SEL];
      sync_mode        <= pwdata[autobaud_pkg::BIT_SYNC_MODE];
      rx_enable        <= pwdata[autobaud_pkg::BIT_RX_ENABLE];
    end
    else
    begin
      // RL6 hardware clears enable
      if (cal_last)
        calib_enable <= 1'b0;
      // RL21 hardware clears wake
      if (wake_done)
        wake_enable <= 1'b0;
    end
  end

  // Break tracking between the two wake edges
  // Dropped while wake is off, so an old break never ends a new one
  always_ff @(posedge clk)
  begin
    if (rst || !wake_active)
      wake_seen <= 1'b0;
    else if (wake_event)
      wake_seen <= 1'b1;
  end

  // Divisor pair, counter during calibration
  always_ff @(posedge clk)
  begin
    if (rst)
      divisor <= autobaud_pkg::DIVISOR_RESET;
    // RL24 cleared at start
    else if (next_cal_state == CAL_HOLD && cal_state == CAL_OFF)
      divisor <= 16'h0000;
    // RL13 closing edge adds one count
    // A tick on the closing edge still counts, so the
    // window is exactly eight bit periods
    else if (cal_last)
      divisor <= divisor + 16'h0001 + {15'h0000, tk.calib_tick};
    // RL8 full 16-bit count, RL9 slow tick
    else if (cal_state == CAL_COUNT && tk.calib_tick)
      divisor <= divisor + 16'h0001;
    // Divisor writes are dropped while it is counting
    else if (wr && hit_low && !calibrating)
      divisor[7:0] <= pwdata[7:0];
    else if (wr && hit_high && !calibrating)
      divisor[15:8] <= pwdata[7:0];
  end

  // Ordinary receiver, one base tick group per bit
  // Simplified: a bit lasts divisor plus one base ticks
  always_ff @(posedge clk)
  begin
    // RL2 held idle, RL17 wake disables reception
    if (rst || calibrating || wake_enable || !rx_enable || sync_mode)
    begin
      rx_state <= RX_IDLE;
      bit_cnt  <= 16'h0000;
      bit_idx  <= 4'h0;
      shift    <= 8'h00;
    end
    else
    begin
      case (rx_state)
        RX_IDLE:
          if (fall)
          begin
            rx_state <= RX_START;
            bit_cnt  <= 16'h0000;
          end
        RX_START:
          if (tk.base_tick)
          begin
            bit_cnt <= bit_cnt + 16'h0001;
            if (bit_cnt == {1'b0, divisor[15:1]})
            begin
              bit_cnt  <= 16'h0000;
              bit_idx  <= 4'h0;
              rx_state <= rx_line ? RX_IDLE : RX_DATA;
            end
          end
        RX_DATA:
          if (tk.base_tick)
          begin
            bit_cnt <= bit_cnt + 16'h0001;
            if (bit_cnt == divisor)
            begin
              bit_cnt <= 16'h0000;
              shift   <= {rx_line, shift[7:1]};
              bit_idx <= bit_idx + 4'h1;
              if (bit_idx == autobaud_pkg::DATA_BITS - 4'h1)
                rx_state <= RX_STOP;
            end
          end
        RX_STOP:
          if (tk.base_tick)
          begin
            bit_cnt <= bit_cnt + 16'h0001;
            if (bit_cnt == divisor)
              rx_state <= RX_IDLE;
          end
        default:
          rx_state <= RX_IDLE;
      endcase
    end
  end

  // Receive data and flag; set wins over the read clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_data_reg <= 8'h00;
      rx_int_flag <= 1'b0;
    end
    else
    begin
      if (rx_done)
        rx_data_reg <= shift;
      // RL19 wake sets flag, RL6 completion sets flag
      if (wake_event || cal_last || rx_done)
        rx_int_flag <= 1'b1;
      // RL20 data read clears flag
      else if (rd && hit_data)
        rx_int_flag <= 1'b0;
    end
  end

  // APB answer, one wait state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      prdata          <= 32'h0000_0000;
      wake_enable_out <= 1'b0;
    end
    else
    begin
      pready          <= access;
      pslverr         <= access && !mapped;
      wake_enable_out <= wake_enable;
      // Unused bits and unmapped reads return zero
      if (rd)
      begin
        prdata <= 32'h0000_0000;
        if (hit_ctl)
          prdata[5:0] <= {rx_enable, sync_mode, high_speed_sel, wide_divisor_sel, wake_enable, calib_enable};
        if (hit_low)
          prdata[7:0] <= divisor[7:0];
        if (hit_high)
          prdata[7:0] <= divisor[15:8];
        if (hit_data)
          prdata[7:0] <= rx_data_reg;
        if (hit_stat)
          prdata[2:0] <= {calibrating, rx_state == RX_IDLE, rx_int_flag};
      end
    end
  end

endmodule : autobaud_wake
`default_nettype wire

// File: shared/autobaud_pkg.sv
// Shared constants for the auto-rate calibration and wake block
package autobaud_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_RATE_CONTROL = 8'h00;
  localparam logic [7:0] OFF_DIVISOR_LOW  = 8'h04;
  localparam logic [7:0] OFF_DIVISOR_HIGH = 8'h08;
  localparam logic [7:0] OFF_RX_DATA      = 8'h0C;
  localparam logic [7:0] OFF_STATUS       = 8'h10;

  // rate_control_reg field positions
  localparam int BIT_CALIB_ENABLE = 0;
  localparam int BIT_WAKE_ENABLE  = 1;
  localparam int BIT_WIDE_DIV_SEL = 2;
  localparam int BIT_HIGH_SPD_SEL = 3;
  localparam int BIT_SYNC_MODE    = 4;
  localparam int BIT_RX_ENABLE    = 5;

  // status register field positions
  localparam int BIT_RX_INT_FLAG = 0;
  localparam int BIT_RX_IDLE     = 1;
  localparam int BIT_CALIB_BUSY  = 2;

  // Reset values
  localparam logic [5:0]  RATE_CONTROL_RESET = 6'h00;
  localparam logic [15:0] DIVISOR_RESET      = 16'h0000;

  // Base clock divide ratios from the oscillator clock
  localparam logic [8:0] BASE_DIV_SLOW = 9'h040;
  localparam logic [8:0] BASE_DIV_MID  = 9'h010;
  localparam logic [8:0] BASE_DIV_FAST = 9'h004;
  // Calibration clock is the base clock divided again by this
  localparam logic [3:0] CALIB_DIV     = 4'h8;

  // Rising edges of the sync character that close the measurement
  localparam logic [2:0] SYNC_RISE_EDGES = 3'h5;
  // Data bits of an ordinary character
  localparam logic [3:0] DATA_BITS       = 4'h8;

endpackage : autobaud_pkg

// File: shared/rate_tick_if.sv
// Tick carrier between the rate prescaler and the receiver core
`timescale 1ns/1ps
`default_nettype none
interface rate_tick_if;
  logic wide_sel;
  logic high_sel;
  logic run;
  logic base_tick;
  logic calib_tick;

  modport core
  (
    output wide_sel,
    output high_sel,
    output run,
    input  base_tick,
    input  calib_tick
  );

  modport prescaler
  (
    input  wide_sel,
    input  high_sel,
    input  run,
    output base_tick,
    output calib_tick
  );
endinterface : rate_tick_if
`default_nettype wire

// File: logic/rate_prescaler.sv
// Base and calibration clock enables derived from the oscillator clock
`timescale 1ns/1ps
`default_nettype none
module rate_prescaler
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Tick link
  rate_tick_if.prescaler tk
);

  function automatic logic [8:0] base_div(input logic wide, input logic high);
    case ({wide, high})
      2'b00:   base_div = autobaud_pkg::BASE_DIV_SLOW;
      2'b11:   base_div = autobaud_pkg::BASE_DIV_FAST;
      default: base_div = autobaud_pkg::BASE_DIV_MID;
    endcase
  endfunction : base_div

  logic [8:0] pre_cnt;
  logic [3:0] cal_cnt;
  wire  logic [8:0] div_now  = base_div(tk.wide_sel, tk.high_sel);
  // Wraps at once if a ratio change leaves the count past the end
  wire  logic       pre_wrap = (pre_cnt >= div_now - 9'h001);
  wire  logic       cal_wrap = (cal_cnt == autobaud_pkg::CALIB_DIV - 4'h1);

  // RL10 divide ratio selection
  always_ff @(posedge clk)
  begin
    if (rst || !tk.run)
    begin
      pre_cnt       <= 9'h000;
      cal_cnt       <= 4'h0;
      tk.base_tick  <= 1'b0;
      tk.calib_tick <= 1'b0;
    end
    else
    begin
      pre_cnt       <= pre_wrap ? 9'h000 : pre_cnt + 9'h001;
      tk.base_tick  <= pre_wrap;
      // RL9 one eighth of base rate
      tk.calib_tick <= pre_wrap && cal_wrap;
      if (pre_wrap)
        cal_cnt <= cal_wrap ? 4'h0 : cal_cnt + 4'h1;
    end
  end

endmodule : rate_prescaler
`default_nettype wire

// File: tb/autobaud_wake_sva.sv
// Port-level checks of the calibration and wake block
`timescale 1ns/1ps
`default_nettype none
module autobaud_wake_sva
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial and status
  input wire logic        rx_line,
  input wire logic        rx_int_flag,
  input wire logic        wake_enable_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_data = psel && !pwrite && paddr == autobaud_pkg::OFF_RX_DATA;
  // Sync mode as last written; wake is ignored there
  logic sync_set;

  always_ff @(posedge clk)
  begin
    if (rst)
      sync_set <= 1'b0;
    else if (psel && penable && pwrite && !pready && paddr == autobaud_pkg::OFF_RATE_CONTROL)
      sync_set <= pwdata[autobaud_pkg::BIT_SYNC_MODE];
  end

  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_mapped: assert property (pready && paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10} |-> !pslverr)
    else $error("error on mapped register");
  chk_err_unmapped: assert property (pready && paddr > 8'h13 |-> pslverr)
    else $error("no error on unmapped address");
  chk_wake_flag: assert property (wake_enable_out && !sync_set && $fell(rx_line) |-> ##[1:4] rx_int_flag)
    else $error("wake edge did not raise flag");
  chk_wake_hold: assert property (wake_enable_out && !rx_line |=> wake_enable_out)
    else $error("wake cleared while line low");
  chk_wake_clear: assert property (wake_enable_out && !sync_set && $rose(rx_line) |-> ##[1:4] !wake_enable_out)
    else $error("wake not cleared at break end");
  chk_sync_no_wake: assert property (wake_enable_out && sync_set && $fell(rx_line) && !rx_int_flag |=> !rx_int_flag)
    else $error("wake acted in synchronous mode");
  chk_flag_clear: assert property (rd_data && penable && pready |-> ##[0:1] !rx_int_flag)
    else $error("data read left flag set");
  chk_flag_hold: assert property (rx_int_flag && !rd_data |=> rx_int_flag)
    else $error("flag dropped without data read");
endmodule : autobaud_wake_sva
`default_nettype wire

// File: tb/serial_node.sv
// Remote serial node driving the receive line
`timescale 1ns/1ps
`default_nettype none
module serial_node
(
  // Clock
  input  wire logic clk,
  // Serial line, idle high
  output var logic  rx_line
);
  initial rx_line = 1'b1;

  // start bit, LSB first, stop bit
  task automatic send(input logic [7:0] data, input int bc);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rx_line <= frame[i];
      repeat (bc) @(posedge clk);
    end
  endtask : send
endmodule : serial_node
`default_nettype wire

// File: tb/autobaud_wake_tb.sv
// Self-checking bench for the calibration and wake block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  cmp_count++; \
  if ((a) !== (b)) \
  begin \
    fails++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); \
  end
module autobaud_wake_tb;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic        sleep_mode;
  logic        rx_int_flag;
  logic        wake_enable_out;
  logic [31:0] rdata;
  logic        rerr;
  logic [15:0] div;
  int          fails;
  int          cmp_count;
  // Control word, bit time in clocks, expected divisor
  logic [15:0] row [4][3] = '{'{16'h0001, 16'h0400, 16'h0011}, '{16'h0009, 16'h1040, 16'h0105},
                              '{16'h0005, 16'h0200, 16'h0021}, '{16'h000D, 16'h0080, 16'h0021}};

  autobaud_wake autobaud_wake_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
    .sleep_mode(sleep_mode), .rx_int_flag(rx_int_flag), .wake_enable_out(wake_enable_out));
  serial_node serial_node_inst (.clk(clk), .rx_line(rx_line));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task check_div(input logic [15:0] exp);
    apb(1'b0, autobaud_pkg::OFF_DIVISOR_LOW, 32'h0);
    div[7:0] = rdata[7:0];
    apb(1'b0, autobaud_pkg::OFF_DIVISOR_HIGH, 32'h0);
    div[15:8] = rdata[7:0];
    `CHK(div, exp)
  endtask : check_div

  task end_of_test;
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (90000) @(posedge clk);
    fails++;
    end_of_test;
  end

  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, sleep_mode} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fails = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      // Stale divisor must not leak into the count
      apb(1'b1, autobaud_pkg::OFF_DIVISOR_LOW, 32'h0000_00FF);
      apb(1'b1, autobaud_pkg::OFF_DIVISOR_HIGH, 32'h0000_00FF);
      apb(1'b1, autobaud_pkg::OFF_RATE_CONTROL, {16'h0, row[i][0]});
      serial_node_inst.send(8'h55, int'(row[i][1]));
      `CHK(rx_int_flag, 1'b1)
      apb(1'b0, autobaud_pkg::OFF_RATE_CONTROL, 32'h0);
      `CHK(rdata[0], 1'b0)
      check_div(row[i][2]);
      apb(1'b0, autobaud_pkg::OFF_RX_DATA, 32'h0);
      `CHK(rx_int_flag, 1'b0)
      $display("calibration row %0d done", i);
    end
    apb(1'b0, 8'h20, 32'h0);
    `CHK({rerr, rdata}, {1'b1, 32'h0})
    $display("unmapped access done");
    apb(1'b1, autobaud_pkg::OFF_RATE_CONTROL, 32'h0000_0002);
    sleep_mode <= 1'b1;
    fork
      serial_node_inst.send(8'h00, 64);
      begin
        repeat (32) @(posedge clk);
        `CHK({rx_int_flag, wake_enable_out}, 2'h3)
      end
    join
    sleep_mode <= 1'b0;
    apb(1'b0, autobaud_pkg::OFF_RATE_CONTROL, 32'h0);
    `CHK({rdata[1], wake_enable_out}, 2'h0)
    apb(1'b0, autobaud_pkg::OFF_RX_DATA, 32'h0);
    `CHK(rx_int_flag, 1'b0)
    $display("wake in sleep done");
    apb(1'b1, autobaud_pkg::OFF_RATE_CONTROL, 32'h0000_0012);
    serial_node_inst.send(8'h00, 16);
    `CHK({rx_int_flag, wake_enable_out}, 2'h1)
    $display("wake in synchronous mode done");
    apb(1'b1, autobaud_pkg::OFF_RATE_CONTROL, 32'h0000_000F);
    serial_node_inst.send(8'h00, 128);
    `CHK(rx_int_flag, 1'b1)
    apb(1'b0, autobaud_pkg::OFF_RX_DATA, 32'h0);
    serial_node_inst.send(8'h55, 128);
    `CHK(rx_int_flag, 1'b1)
    check_div(16'h0021);
    $display("wake then calibration done");
    apb(1'b0, autobaud_pkg::OFF_RX_DATA, 32'h0);
    apb(1'b1, autobaud_pkg::OFF_DIVISOR_LOW, 32'h0000_0003);
    apb(1'b1, autobaud_pkg::OFF_DIVISOR_HIGH, 32'h0000_0000);
    apb(1'b1, autobaud_pkg::OFF_RATE_CONTROL, 32'h0000_002C);
    serial_node_inst.send(8'hA5, 16);
    `CHK(rx_int_flag, 1'b1)
    apb(1'b0, autobaud_pkg::OFF_RX_DATA, 32'h0);
    `CHK({rx_int_flag, rdata[7:0]}, {1'b0, 8'hA5})
    // Flag left set, so the reset below must clear it
    serial_node_inst.send(8'h5A, 16);
    $display("ordinary reception done");
    apb(1'b1, autobaud_pkg::OFF_DIVISOR_LOW, 32'h0000_0008);
    apb(1'b1, autobaud_pkg::OFF_DIVISOR_HIGH, 32'h0000_0002);
    check_div(16'h0208);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, autobaud_pkg::OFF_RATE_CONTROL, 32'h0);
    `CHK({rx_int_flag, rdata[5:0]}, {1'b0, autobaud_pkg::RATE_CONTROL_RESET})
    check_div(autobaud_pkg::DIVISOR_RESET);
    $display("reset values done");
    end_of_test;
  end
endmodule : autobaud_wake_tb

bind autobaud_wake autobaud_wake_sva autobaud_wake_sva_inst (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .rx_line(rx_line), .rx_int_flag(rx_int_flag), .wake_enable_out(wake_enable_out));
`default_nettype wire
